// >>> shared/pbcs_pkg.sv
// Constants, field positions and types for the basic control and status registers
package pbcs_pkg;

  // Register addresses on the management interface
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STAT = 5'h01;

  // Control register field positions
  localparam int CB_SPEED_LO = 13;
  localparam int CB_AN_EN = 12;
  localparam int CB_ISOLATE = 10;
  localparam int CB_RESTART = 9;
  localparam int CB_DUPLEX = 8;
  localparam int CB_COLTEST = 7;
  localparam int CB_SPEED_HI = 6;

  // Control reset values that do not come from straps
  localparam logic CTRL_ISOLATE_RST = 1'h0;
  localparam logic CTRL_COLTEST_RST = 1'h0;
  localparam logic CTRL_SPEED_HI_RST = 1'h1;
  localparam logic CTRL_SPEED_LO_RST = 1'h0;

  // Status register: fixed ability bits and live field positions
  localparam logic [15:0] STAT_CONST = 16'h7948;
  localparam logic [15:0] STAT_CONST_MASK = 16'hFFCB;
  localparam int SB_AN_DONE = 5;
  localparam int SB_RFAULT = 4;
  localparam int SB_LINK = 2;

  // Forced speed codes, high bit first
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [1:0] SPD_RSVD = 2'h3;

  // Serial management frame fields
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam int PRE_LEN = 32;
  localparam logic [4:0] PRE_LAST = 5'(PRE_LEN - 1);
  localparam logic [4:0] OP_LAST = 5'h01;
  localparam logic [4:0] ADDR_LAST = 5'h04;
  localparam logic [4:0] TA_LAST = 5'h01;
  localparam logic [4:0] DATA_LAST = 5'h0F;

  // Collision test timing, in bit times at the fastest line rate
  localparam int CLK_PERIOD_PS = 50000;
  localparam int BIT_PS = 1000;
  localparam int COL_ON_BITS = 512;
  localparam int COL_OFF_BITS = 4;
  localparam int COL_ON_CYC = (COL_ON_BITS * BIT_PS >= CLK_PERIOD_PS) ?
    (COL_ON_BITS * BIT_PS) / CLK_PERIOD_PS : 1;
  localparam int COL_OFF_CYC = (COL_OFF_BITS * BIT_PS >= CLK_PERIOD_PS) ?
    (COL_OFF_BITS * BIT_PS) / CLK_PERIOD_PS : 1;

  // Frame engine states
  typedef enum logic [2:0] {
    MD_PREAMBLE, MD_IDLE, MD_START, MD_OP, MD_PHY, MD_REG, MD_TA, MD_DATA
  } pbcs_mdio_e;

endpackage : pbcs_pkg

// >>> shared/pbcs_mgmt_if.sv
// Register access strobes between the frame engine and the register bank
`timescale 1ns/1ps
interface pbcs_mgmt_if;
  logic [4:0] addr;
  logic rd_strobe;
  logic [15:0] rd_data;
  logic wr_strobe;
  logic [15:0] wr_data;

  modport frame (output addr, output rd_strobe, input rd_data,
    output wr_strobe, output wr_data);
  modport bank (input addr, input rd_strobe, output rd_data,
    input wr_strobe, input wr_data);
endinterface : pbcs_mgmt_if

// >>> logic/pbcs_mdio_slave.sv
// Serial management frame engine: preamble, frame decode, read and write strobes
`timescale 1ns/1ps
module pbcs_mdio_slave (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  pbcs_mgmt_if.frame m
);
  import pbcs_pkg::*;

  pbcs_mdio_e state, next_state;
  logic [4:0] cnt, next_cnt;
  logic [15:0] sh, next_sh;
  logic [15:0] tx, next_tx;
  logic [1:0] op, next_op;
  logic [4:0] addr, next_addr;
  logic hit, next_hit;
  logic out, next_out;
  logic oe, next_oe;
  logic mdc_d;
  logic rise;
  logic [15:0] shin;

  // Edge of the management clock and the shifted-in word
  assign rise = mdc & ~mdc_d;
  assign shin = {sh[14:0], mdio_in};
  assign mdio_out = out;
  assign mdio_oe = oe;

  // Register strobes land in the cycle the frame reaches them
  assign m.addr = addr;
  assign m.rd_strobe = rise && state == MD_TA && cnt == 5'h00 && op == OP_READ && hit;
  assign m.wr_strobe = rise && state == MD_DATA && cnt == DATA_LAST &&
    op == OP_WRITE && hit;
  assign m.wr_data = shin;

  // Frame sequencing, one step per rising management clock edge
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_tx = tx;
    next_op = op;
    next_addr = addr;
    next_hit = hit;
    next_out = out;
    next_oe = oe;
    if (rise) begin
      next_sh = shin;
      next_cnt = cnt + 5'h01;
      unique case (state)
        MD_PREAMBLE: begin
          if (!mdio_in) next_cnt = 5'h00;
          else if (cnt == PRE_LAST) next_state = MD_IDLE;
        end
        MD_IDLE: begin
          next_cnt = 5'h00;
          if (!mdio_in) next_state = MD_START;
        end
        MD_START: begin
          next_cnt = 5'h00;
          next_state = mdio_in ? MD_OP : MD_PREAMBLE;
        end
        MD_OP: if (cnt == OP_LAST) begin
          next_op = shin[1:0];
          next_cnt = 5'h00;
          next_state = (shin[1:0] == OP_READ || shin[1:0] == OP_WRITE) ? MD_PHY
            : MD_PREAMBLE;
        end
        MD_PHY: if (cnt == ADDR_LAST) begin
          next_hit = shin[4:0] == phy_addr;
          next_cnt = 5'h00;
          next_state = MD_REG;
        end
        MD_REG: if (cnt == ADDR_LAST) begin
          next_addr = shin[4:0];
          next_cnt = 5'h00;
          next_state = MD_TA;
        end
        MD_TA: begin
          if (m.rd_strobe) begin
            next_tx = m.rd_data;
            next_oe = 1'h1;
            next_out = 1'h0;
          end
          if (cnt == TA_LAST) begin
            next_cnt = 5'h00;
            next_state = MD_DATA;
            if (op == OP_WRITE && shin[1:0] != TA_WRITE) next_state = MD_PREAMBLE;
            next_out = tx[15];
            next_tx = {tx[14:0], 1'h0};
          end
        end
        MD_DATA: begin
          next_out = tx[15];
          next_tx = {tx[14:0], 1'h0};
          if (cnt == DATA_LAST) begin
            next_cnt = 5'h00;
            next_oe = 1'h0;
            next_out = 1'h0;
            next_state = MD_IDLE;
          end
        end
      endcase
    end
  end

  // Frame engine registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= MD_PREAMBLE;
      cnt <= 5'h00;
      sh <= 16'h0000;
      tx <= 16'h0000;
      op <= 2'h0;
      addr <= 5'h00;
      hit <= 1'h0;
      out <= 1'h0;
      oe <= 1'h0;
      mdc_d <= 1'h1; // No false edge if the clock idles high at release
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sh <= next_sh;
      tx <= next_tx;
      op <= next_op;
      addr <= next_addr;
      hit <= next_hit;
      out <= next_out;
      oe <= next_oe;
      mdc_d <= mdc;
    end
  end

endmodule : pbcs_mdio_slave

// >>> logic/pbcs_regs.sv
// Basic control and status register bank behind the serial management port
`timescale 1ns/1ps
module pbcs_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  input wire logic strap_an_enable,
  input wire logic strap_full_duplex,
  input wire logic an_begun,
  input wire logic an_complete,
  input wire logic [1:0] an_speed,
  input wire logic an_full_duplex,
  input wire logic link_good,
  input wire logic far_end_fault,
  input wire logic lp_remote_fault,
  input wire logic tx_en,
  output logic col,
  output logic an_restart,
  output logic an_enabled,
  output logic port_isolate,
  output logic [1:0] port_speed,
  output logic port_full_duplex
);
  import pbcs_pkg::*;

  localparam int COL_ON_MAX = COL_ON_CYC;
  localparam int COL_OFF_MAX = COL_OFF_CYC;

  pbcs_mgmt_if m ();

  // Control register state
  logic isolate, next_isolate;
  logic restart, next_restart;
  logic duplex, next_duplex;
  logic coltest, next_coltest;
  logic spd_hi, next_spd_hi;
  logic spd_lo, next_spd_lo;
  logic an_en, next_an_en;

  // Status latches and port outputs
  logic rfault, next_rfault;
  logic link, next_link;
  logic col_q, next_col;
  logic [1:0] speed_q, next_speed;
  logic fdx_q, next_fdx;

  logic wr_ctrl;
  logic wr_stat;
  logic rd_stat;
  logic [15:0] wd;
  logic [15:0] ctrl_word;
  logic [15:0] stat_word;
  logic [1:0] forced;

  // Frame engine drives the strobes
  pbcs_mdio_slave u_mdio (
    .sys_clk(sys_clk),
    .rst(rst),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .phy_addr(phy_addr),
    .m(m.frame)
  );

  // Access decode
  assign wd = m.wr_data;
  assign wr_ctrl = m.wr_strobe && m.addr == ADDR_CTRL;
  assign wr_stat = m.wr_strobe && m.addr == ADDR_STAT;
  assign rd_stat = m.rd_strobe && m.addr == ADDR_STAT;
  assign forced = {spd_hi, spd_lo};

  // Read words; unmapped addresses read zero
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[CB_SPEED_LO] = spd_lo;
    ctrl_word[CB_AN_EN] = an_en;
    ctrl_word[CB_ISOLATE] = isolate;
    ctrl_word[CB_RESTART] = restart;
    ctrl_word[CB_DUPLEX] = duplex;
    ctrl_word[CB_COLTEST] = coltest;
    ctrl_word[CB_SPEED_HI] = spd_hi;
    stat_word = STAT_CONST;
    stat_word[SB_AN_DONE] = an_complete;
    stat_word[SB_RFAULT] = rfault;
    stat_word[SB_LINK] = link;
    if (m.addr == ADDR_CTRL) m.rd_data = ctrl_word;
    else if (m.addr == ADDR_STAT) m.rd_data = stat_word;
    else m.rd_data = 16'h0000;
  end

  // Control register next values
  always_comb begin
    next_isolate = isolate;
    next_duplex = duplex;
    next_coltest = coltest;
    next_spd_hi = spd_hi;
    next_spd_lo = spd_lo;
    next_an_en = an_en;
    next_restart = restart;
    if (an_begun) next_restart = 1'h0;
    if (wr_ctrl) begin
      next_isolate = wd[CB_ISOLATE];
      next_duplex = wd[CB_DUPLEX];
      next_coltest = wd[CB_COLTEST];
      next_spd_hi = wd[CB_SPEED_HI];
      next_spd_lo = wd[CB_SPEED_LO];
      next_an_en = wd[CB_AN_EN];
      // A written zero leaves a pending restart alone unless the same write clears negotiation enable
      if (wd[CB_RESTART] && wd[CB_AN_EN]) next_restart = 1'h1;
    end
    next_restart = next_restart & next_an_en;
  end

  // Latched status bits; the event wins over the read clear
  always_comb begin
    next_rfault = rfault;
    next_link = link;
    if (rd_stat) begin
      next_rfault = 1'h0;
      next_link = link_good;
    end
    if (far_end_fault || lp_remote_fault) next_rfault = 1'h1;
    if (!link_good) next_link = 1'h0;
    // Status writes reach none of these terms
  end

  // Port mode and collision test outputs
  always_comb begin
    next_speed = speed_q;
    next_fdx = fdx_q;
    if (an_en) begin
      next_speed = an_speed;
      next_fdx = an_full_duplex;
    end else begin
      next_fdx = duplex;
      if (forced != SPD_RSVD) next_speed = forced;
    end
    next_col = coltest && tx_en && !isolate;
  end

  // Register bank state; straps are caught while reset is held
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      isolate <= CTRL_ISOLATE_RST;
      restart <= 1'h0;
      duplex <= strap_full_duplex;
      coltest <= CTRL_COLTEST_RST;
      spd_hi <= CTRL_SPEED_HI_RST;
      spd_lo <= CTRL_SPEED_LO_RST;
      an_en <= strap_an_enable;
      rfault <= 1'h0;
      link <= 1'h0;
      col_q <= 1'h0;
      speed_q <= SPD_10;
      fdx_q <= 1'h0;
    end else begin
      isolate <= next_isolate;
      restart <= next_restart;
      duplex <= next_duplex;
      coltest <= next_coltest;
      spd_hi <= next_spd_hi;
      spd_lo <= next_spd_lo;
      an_en <= next_an_en;
      rfault <= next_rfault;
      link <= next_link;
      col_q <= next_col;
      speed_q <= next_speed;
      fdx_q <= next_fdx;
    end
  end

  // Outputs straight from registers
  assign col = col_q;
  assign an_restart = restart;
  assign an_enabled = an_en;
  assign port_isolate = isolate;
  assign port_speed = speed_q;
  assign port_full_duplex = fdx_q;

  // Checks on the register bank
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  AST_ISOLATE_FOLLOWS: assert property (
    wr_ctrl |=> port_isolate == $past(wd[CB_ISOLATE]))
    else $error("isolate output did not follow the write");

  AST_RESTART_SET: assert property (
    wr_ctrl && wd[CB_RESTART] && wd[CB_AN_EN] |=> an_restart)
    else $error("restart bit not set by write");

  AST_RESTART_IGNORED: assert property (
    wr_ctrl && !wd[CB_AN_EN] |=> !an_restart)
    else $error("restart accepted with negotiation off");

  AST_RESTART_KEEPS: assert property (
    an_restart && !an_begun && !(wr_ctrl && !wd[CB_AN_EN]) |=> an_restart)
    else $error("pending restart lost without negotiation start");

  AST_RESTART_CLEARS: assert property (
    an_restart && an_begun && !wr_ctrl |=> !an_restart)
    else $error("restart bit did not self-clear");

  AST_FORCED_DUPLEX: assert property (
    !an_enabled && $stable(an_enabled) |=> port_full_duplex == $past(duplex))
    else $error("forced duplex not applied");

  AST_FORCED_GIGA: assert property (
    !an_en && forced == SPD_1000 |=> port_speed == SPD_1000)
    else $error("forced 1000 speed not applied");

  AST_AN_OVERRIDES: assert property (
    an_en |=> port_speed == $past(an_speed) && port_full_duplex == $past(an_full_duplex))
    else $error("negotiated mode not applied");

  AST_COL_ON: assert property (
    coltest && !isolate && tx_en [*2] |-> ##[0:COL_ON_MAX] col)
    else $error("collision test output late");

  AST_COL_OFF: assert property (
    $fell(tx_en) |-> ##[0:COL_OFF_MAX] !col)
    else $error("collision output held after transmit end");

  AST_CTRL_LOW_ZERO: assert property (
    m.addr == ADDR_CTRL |-> m.rd_data[5:0] == 6'h00)
    else $error("control reserved bits not zero");

  AST_STAT_FIXED: assert property (
    m.addr == ADDR_STAT |-> (m.rd_data & STAT_CONST_MASK) == STAT_CONST)
    else $error("status fixed bits wrong");

  AST_AN_DONE: assert property (
    m.addr == ADDR_STAT |-> m.rd_data[SB_AN_DONE] == an_complete)
    else $error("negotiation complete bit wrong");

  AST_RFAULT_HOLD: assert property (
    rfault && !rd_stat |=> rfault)
    else $error("remote fault dropped without read");

  AST_LINK_LOW: assert property (
    !link_good |=> !link)
    else $error("link bit high after failure");

  AST_LINK_NEEDS_READ: assert property (
    !link && !rd_stat |=> !link)
    else $error("link bit rose without a read");

  AST_STAT_WRITE: assert property (
    wr_stat && link_good && !far_end_fault && !lp_remote_fault |=>
      $stable(link) && $stable(rfault))
    else $error("status write changed latched bits");

  COV_RESTART: cover property (an_restart ##[1:8] !an_restart);
  COV_RFAULT_READ: cover property (rfault ##1 rd_stat ##1 !rfault);
  COV_LINK_BACK: cover property (!link ##1 rd_stat ##1 link);
  COV_COL_TEST: cover property (coltest && tx_en ##1 col);

endmodule : pbcs_regs

// >>> dv/pbcs_mac_model.sv
// Station management controller model that drives serial management frames
`timescale 1ns/1ps
module pbcs_mac_model import pbcs_pkg::*; #(
  parameter logic [4:0] PHY = 5'h19
) (
  input wire logic sys_clk,
  input wire logic mdio,
  output logic mdc,
  output logic mac_out,
  output logic mac_oe
);
  // Line released and clock parked until the first frame
  initial begin
    mdc = 1'h0;
    mac_out = 1'h1;
    mac_oe = 1'h0;
  end

  // One bit period: clock low two cycles, line sampled, clock high two cycles
  task automatic bit_slot(input logic drive, input logic val, output logic seen);
    @(negedge sys_clk);
    mac_oe = drive;
    mac_out = val;
    mdc = 1'h0;
    repeat (2) @(negedge sys_clk);
    seen = mdio;
    mdc = 1'h1;
    @(negedge sys_clk);
  endtask : bit_slot

  // Whole frame; on reads the turnaround and data slots are left undriven
  task automatic xfer(input logic pre, input logic [1:0] op, input logic [4:0] ra,
      input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] frm;
    logic s;
    frm = {2'h1, op, PHY, ra, TA_WRITE, wd};
    rd = 16'h0000;
    if (pre) for (int i = 0; i < PRE_LEN; i++) bit_slot(1'h1, 1'h1, s);
    for (int i = 31; i >= 0; i--) begin
      bit_slot(!(op == OP_READ && i < 18), frm[i], s);
      if (i < 16) rd[i] = s;
    end
    @(negedge sys_clk);
    mac_oe = 1'h0; // Released line floats to the pull-up
    mdc = 1'h0; // Clock parked low between frames
  endtask : xfer
endmodule : pbcs_mac_model

// >>> dv/phy_basic_control_status_regs_test.sv
// Testbench for the basic control and status register bank
`timescale 1ns/1ps
module phy_basic_control_status_regs_test import pbcs_pkg::*;;
  logic sys_clk, rst, mdc, mdio_in, mdio_out, mdio_oe, mac_out, mac_oe;
  logic strap_an_enable, strap_full_duplex, an_begun, an_complete, an_full_duplex;
  logic link_good, far_end_fault, lp_remote_fault, tx_en, col, an_restart;
  logic an_enabled, port_isolate, port_full_duplex;
  logic [1:0] an_speed, port_speed;
  int fails = 0;
  int comparisons = 0;

  // Shared data line with pull-up
  assign mdio_in = mdio_oe ? mdio_out : (mac_oe ? mac_out : 1'h1);

  pbcs_regs dut (.sys_clk(sys_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(5'h19),
    .strap_an_enable(strap_an_enable), .strap_full_duplex(strap_full_duplex),
    .an_begun(an_begun), .an_complete(an_complete), .an_speed(an_speed),
    .an_full_duplex(an_full_duplex), .link_good(link_good), .far_end_fault(far_end_fault),
    .lp_remote_fault(lp_remote_fault), .tx_en(tx_en), .col(col), .an_restart(an_restart),
    .an_enabled(an_enabled), .port_isolate(port_isolate), .port_speed(port_speed),
    .port_full_duplex(port_full_duplex));

  pbcs_mac_model mac (.sys_clk(sys_clk), .mdio(mdio_in), .mdc(mdc), .mac_out(mac_out),
    .mac_oe(mac_oe));

  // 50 ns clock
  always #25 sys_clk = ~sys_clk;

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    mac.xfer(1'h0, OP_WRITE, ra, wd, d);
  endtask : wr

  task automatic rd(input logic [4:0] ra, output logic [15:0] r);
    mac.xfer(1'h0, OP_READ, ra, 16'h0000, r);
  endtask : rd

  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // Watchdog at about five times the expected run of some 4100 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    summarize();
  end

  // Main sequence
  initial begin
    logic [15:0] r;
    logic [15:0] w;
    sys_clk = 1'h0;
    rst = 1'h1;
    strap_an_enable = 1'h1;
    strap_full_duplex = 1'h1;
    {an_begun, an_complete, an_full_duplex, far_end_fault, lp_remote_fault, tx_en} = 6'h00;
    an_speed = 2'h1;
    link_good = 1'h1;
    repeat (20) @(negedge sys_clk);
    rst = 1'h0;
    chk_bit("mdio_oe idle", 1'h0, mdio_oe);
    mac.xfer(1'h1, OP_READ, ADDR_CTRL, 16'h0000, r);
    chk16("ctrl reset", 16'h1140, r);
    chk_bit("an_enabled", 1'h1, an_enabled);
    chk16("auto speed", 16'h0001, {14'h0, port_speed});
    chk_bit("auto duplex", 1'h0, port_full_duplex);
    rd(ADDR_STAT, r);
    chk16("stat fixed", 16'h7948, r & 16'hFFCB);
    rd(ADDR_STAT, r);
    chk16("stat idle", 16'h794C, r);
    // Forced speed and duplex codes, reserved low bits written as ones
    for (int i = 0; i < 4; i++) begin
      w = 16'h003F | (i[0] ? 16'h2100 : 16'h0000) | (i[1] ? 16'h0040 : 16'h0000);
      wr(ADDR_CTRL, w);
      rd(ADDR_CTRL, r);
      chk16("ctrl forced", w & 16'h2140, r);
      chk16("forced speed", (i == 3) ? 16'h0002 : 16'(i), {14'h0, port_speed});
      chk_bit("forced duplex", i[0], port_full_duplex);
    end
    // Restart ignored while negotiation off, then honoured and self-cleared
    wr(ADDR_CTRL, 16'h0200);
    chk_bit("restart off", 1'h0, an_restart);
    wr(ADDR_CTRL, 16'h1200);
    chk_bit("restart on", 1'h1, an_restart);
    wr(ADDR_CTRL, 16'h1000);
    chk_bit("restart kept", 1'h1, an_restart);
    rd(ADDR_CTRL, r);
    chk16("restart bit", 16'h1200, r);
    an_begun = 1'h1;
    @(negedge sys_clk);
    an_begun = 1'h0;
    repeat (2) @(negedge sys_clk);
    chk_bit("restart clear", 1'h0, an_restart);
    rd(ADDR_CTRL, r);
    chk16("restart read", 16'h1000, r);
    // Isolated port keeps management and suppresses collision
    wr(ADDR_CTRL, 16'h1480);
    tx_en = 1'h1;
    repeat (COL_ON_CYC) @(negedge sys_clk);
    chk_bit("isolate", 1'h1, port_isolate);
    chk_bit("col isolated", 1'h0, col);
    rd(ADDR_CTRL, r);
    chk16("ctrl isolated", 16'h1480, r);
    tx_en = 1'h0;
    wr(ADDR_CTRL, 16'h1080);
    chk_bit("isolate off", 1'h0, port_isolate);
    tx_en = 1'h1;
    repeat (COL_ON_CYC) @(negedge sys_clk);
    chk_bit("col on", 1'h1, col);
    tx_en = 1'h0;
    repeat (COL_OFF_CYC) @(negedge sys_clk);
    chk_bit("col off", 1'h0, col);
    // Latched status bits, and a status write that changes nothing
    {an_complete, far_end_fault, link_good} = 3'h6;
    @(negedge sys_clk);
    {far_end_fault, link_good} = 2'h1;
    wr(ADDR_STAT, 16'h0000);
    rd(ADDR_STAT, r);
    chk16("stat latched", 16'h7978, r);
    rd(ADDR_STAT, r);
    chk16("stat cleared", 16'h796C, r);
    {an_complete, lp_remote_fault} = 2'h1;
    @(negedge sys_clk);
    lp_remote_fault = 1'h0;
    rd(ADDR_STAT, r);
    chk16("stat partner fault", 16'h795C, r);
    // Invalid opcode loses sync until a fresh preamble
    mac.xfer(1'h0, 2'h0, ADDR_CTRL, 16'hFFFF, r);
    rd(ADDR_CTRL, r);
    chk16("no sync", 16'hFFFF, r);
    mac.xfer(1'h1, OP_READ, ADDR_CTRL, 16'h0000, r);
    chk16("resync", 16'h1080, r);
    // Mid-run reset clears latches, recaptures straps and needs a fresh preamble
    {strap_an_enable, strap_full_duplex, far_end_fault} = 3'h1;
    @(negedge sys_clk);
    far_end_fault = 1'h0;
    rst = 1'h1;
    repeat (20) @(negedge sys_clk);
    rst = 1'h0;
    chk_bit("an_enabled strap", 1'h0, an_enabled);
    chk_bit("isolate reset", 1'h0, port_isolate);
    mac.xfer(1'h1, OP_READ, ADDR_CTRL, 16'h0000, r);
    chk16("ctrl rereset", 16'h0040, r);
    rd(ADDR_STAT, r);
    chk16("stat reset", 16'h7948, r);
    chk16("speed after reset", 16'h0002, {14'h0, port_speed});
    summarize();
  end
endmodule : phy_basic_control_status_regs_test
